// ==== core/flash_srw_pkg.sv ====
// Shared constants and types for the pause/continue/wrap command logic and its host.
package flash_srw_pkg;
	// Opcodes
	localparam logic [7:0] OP_SUSPEND_A = 8'hB0;
	localparam logic [7:0] OP_SUSPEND_B = 8'h75;
	localparam logic [7:0] OP_RESUME_A = 8'h7A;
	localparam logic [7:0] OP_RESUME_B = 8'hD0;
	localparam logic [7:0] OP_SET_WRAP = 8'h77;
	localparam logic [7:0] OP_READ_STATUS = 8'h05;
	// Frame lengths in serial clocks
	localparam int OPCODE_CLOCKS = 8;
	localparam int ADDR_CLOCKS = 6;
	localparam int WRAP_CLOCKS = 2;
	localparam int WRAP_FRAME_CLOCKS = OPCODE_CLOCKS + ADDR_CLOCKS + WRAP_CLOCKS;
	localparam int STATUS_FRAME_CLOCKS = 16;
	localparam int WRAP_NIB_FIRST = OPCODE_CLOCKS + ADDR_CLOCKS;
	// Timing: latencies are longest times, so the cycle count rounds down
	localparam int CLOCK_MHZ = 40;
	localparam int PAUSE_LATENCY_NS = 20000;
	localparam int CONTINUE_LATENCY_NS = 5000;
	localparam int PAUSE_CYCLES = (PAUSE_LATENCY_NS * CLOCK_MHZ / 1000 < 1) ? 1 : PAUSE_LATENCY_NS * CLOCK_MHZ / 1000;
	localparam int CONTINUE_CYCLES = (CONTINUE_LATENCY_NS * CLOCK_MHZ / 1000 < 1) ? 1 :
		CONTINUE_LATENCY_NS * CLOCK_MHZ / 1000;
	localparam int SCLK_HALF = 4;
	localparam int CS_GAP_CYCLES = 8;
	// Status byte bit positions
	localparam int ST_BUSY = 0;
	localparam int ST_WLATCH = 1;
	localparam int ST_PAUSED = 2;
	localparam int ST_ERASE_PAUSED = 3;
	localparam int ST_PROG_PAUSED = 4;
	// Wrap field: wrap_length_bits[0] is the wrap-off bit, taken from wrap byte bits 6:4
	localparam int WRAP_FIELD_LSB = 4;
	localparam logic [2:0] WRAP_RESET = 3'h1;
	localparam int WRAP_MIN_BYTES = 8;

	typedef enum logic [2:0] {KIND_PROGRAM = 3'b001, KIND_ERASE = 3'b010, KIND_LOCKED = 3'b100} op_kind_e;
	typedef enum logic [3:0] {ENG_IDLE = 4'b0001, ENG_RUN = 4'b0010, ENG_PAUSING = 4'b0100,
		ENG_RESUMING = 4'b1000} eng_state_e;
	typedef enum logic [3:0] {HCMD_SUSPEND = 4'b0001, HCMD_RESUME = 4'b0010, HCMD_SET_WRAP = 4'b0100,
		HCMD_READ_STATUS = 4'b1000} host_cmd_e;
	typedef enum logic [2:0] {H_IDLE = 3'b001, H_SHIFT = 3'b010, H_GAP = 3'b100} host_state_e;
endpackage : flash_srw_pkg

// ==== core/flash_link_if.sv ====
// Serial link between host controller and flash command logic.
`timescale 1ns/10ps
interface flash_link_if;
	logic csN;
	logic sclk;
	logic [3:0] ioHost;
	logic [3:0] ioHostOe;
	logic [3:0] ioDev;
	logic [3:0] ioDevOe;
	wire [3:0] io;

	// Resolved data lines; an undriven line floats high as with a pull-up
	genvar i;
	for (i = 0; i < 4; i++) begin : g_line
		assign io[i] = ioHostOe[i] ? ioHost[i] : (ioDevOe[i] ? ioDev[i] : 1'b1);
	end

	modport host (output csN, output sclk, output ioHost, output ioHostOe, input io);
	modport device (input csN, input sclk, input io, output ioDev, output ioDevOe);
endinterface : flash_link_if

// ==== core/flash_srw_device.sv ====
// Flash command logic: program/erase pause and continue, burst wrap setting.
`timescale 1ns/10ps
module flash_srw_device #(
	parameter int PAUSE_CYCLES = flash_srw_pkg::PAUSE_CYCLES,
	parameter int CONTINUE_CYCLES = flash_srw_pkg::CONTINUE_CYCLES,
	parameter int CNT_W = 16
) (
	input wire logic clock,
	input wire logic resetn,
	flash_link_if.device link,
	input wire logic startOp,
	input wire flash_srw_pkg::op_kind_e startKind,
	input wire logic [CNT_W-1:0] startCycles,
	input wire logic writeLatch,
	input wire logic rdLoad,
	input wire logic [23:0] rdStart,
	input wire logic rdStep,
	output logic busyFlag,
	output logic pausedOpFlag,
	output logic erasePausedFlag,
	output logic programPausedFlag,
	output logic [2:0] wrapLengthBits,
	output logic startRefused,
	output logic opFinished,
	output logic [23:0] rdAddr
);
	// ---------------- link domain (serial clock) ----------------
	logic fresh;
	logic [5:0] clkCount;
	logic [7:0] opcode;
	logic [7:0] wrapByte;
	logic [7:0] statSync1;
	logic [7:0] statSync2;
	logic soBit;
	logic soOe;
	logic [7:0] statusByte;
	wire [5:0] curCount;
	wire [5:0] incCount;
	wire readWindow;
	wire [2:0] readIdx;

	// A new frame restarts counting; set while select is high before the frame, cleared by its first clock
	always_ff @(posedge link.sclk or posedge link.csN) begin
		if (link.csN) begin
			fresh <= 1'b1;
		end else begin
			fresh <= 1'b0;
		end
	end

	assign curCount = fresh ? 6'h00 : clkCount;
	assign incCount = (curCount == 6'h3F) ? curCount : curCount + 6'h01;

	// Shift opcode on line 0 and the wrap byte as two nibbles on all four lines
	always_ff @(posedge link.sclk) begin
		clkCount <= incCount;
		if (curCount < 6'(flash_srw_pkg::OPCODE_CLOCKS)) begin
			opcode <= {opcode[6:0], link.io[0]};
		end
		if (curCount >= 6'(flash_srw_pkg::WRAP_NIB_FIRST) && curCount < 6'(flash_srw_pkg::WRAP_FRAME_CLOCKS)) begin
			wrapByte <= {wrapByte[3:0], link.io};
		end
		statSync1 <= statusByte;
		statSync2 <= statSync1;
	end

	// Status byte leaves on line 1, MSB first, on falling edges after the opcode
	assign readWindow = (opcode == flash_srw_pkg::OP_READ_STATUS) &&
		(clkCount >= 6'(flash_srw_pkg::OPCODE_CLOCKS)) && (clkCount < 6'(flash_srw_pkg::STATUS_FRAME_CLOCKS));
	assign readIdx = 3'h7 - clkCount[2:0];

	always_ff @(negedge link.sclk or posedge link.csN) begin
		if (link.csN) begin
			soOe <= 1'b0;
			soBit <= 1'b0;
		end else begin
			soOe <= readWindow;
			soBit <= statSync2[readIdx];
		end
	end

	assign link.ioDev = {2'b00, soBit, 1'b0};
	assign link.ioDevOe = {2'b00, soOe & ~link.csN, 1'b0};

	// ---------------- core domain ----------------
	logic csSync1;
	logic csSync2;
	logic csPrev;
	flash_srw_pkg::eng_state_e state;
	flash_srw_pkg::op_kind_e runKind;
	logic [CNT_W-1:0] remain;
	logic [CNT_W-1:0] savedErase;
	logic [CNT_W-1:0] savedProg;
	logic [15:0] latTimer;

	// Frame length check: opcode complete and select released on a byte boundary
	function automatic logic frameWhole(input logic [5:0] count, input int need);
		frameWhole = (count >= 6'(need)) && (count[2:0] == 3'h0);
	endfunction : frameWhole

	// Next address inside an aligned wrap section, or linear when wrap is off
	function automatic logic [23:0] wrapNext(input logic [23:0] addr, input logic [2:0] bits);
		logic [23:0] mask;
		mask = 24'(flash_srw_pkg::WRAP_MIN_BYTES - 1);
		mask = (24'(flash_srw_pkg::WRAP_MIN_BYTES) << bits[2:1]) - 24'h00_0001;
		if (bits[0]) begin
			wrapNext = addr + 24'h00_0001;
		end else begin
			wrapNext = (addr & ~mask) | ((addr + 24'h00_0001) & mask);
		end
	endfunction : wrapNext

	wire csRise;
	wire isSuspend;
	wire isResume;
	wire isSetWrap;
	wire suspendOk;
	wire resumeOk;
	wire kindAllowed;
	wire startOk;
	wire anyPaused;

	assign csRise = csSync2 & ~csPrev;
	// Link registers hold still while select is high, so they are read directly here
	assign isSuspend = (opcode == flash_srw_pkg::OP_SUSPEND_A) || (opcode == flash_srw_pkg::OP_SUSPEND_B);
	assign isResume = (opcode == flash_srw_pkg::OP_RESUME_A) || (opcode == flash_srw_pkg::OP_RESUME_B);
	assign isSetWrap = (opcode == flash_srw_pkg::OP_SET_WRAP);
	assign anyPaused = erasePausedFlag | programPausedFlag;
	// Write latch is not consulted for pause or continue
	assign suspendOk = csRise && isSuspend && frameWhole(clkCount, flash_srw_pkg::OPCODE_CLOCKS)
		&& (state == flash_srw_pkg::ENG_RUN) && (runKind != flash_srw_pkg::KIND_LOCKED);
	assign resumeOk = csRise && isResume && frameWhole(clkCount, flash_srw_pkg::OPCODE_CLOCKS)
		&& anyPaused && !busyFlag;
	assign kindAllowed = (startKind == flash_srw_pkg::KIND_PROGRAM) ? !programPausedFlag :
		(startKind == flash_srw_pkg::KIND_ERASE) ? !anyPaused : !anyPaused;
	assign startOk = startOp && (state == flash_srw_pkg::ENG_IDLE) && !resumeOk && kindAllowed;
	assign busyFlag = (state != flash_srw_pkg::ENG_IDLE);
	assign statusByte = {3'h0, programPausedFlag, erasePausedFlag, pausedOpFlag, writeLatch, busyFlag};

	// Select synchroniser; idles high
	always_ff @(posedge clock) begin
		if (!resetn) begin
			csSync1 <= 1'b1;
			csSync2 <= 1'b1;
			csPrev <= 1'b1;
		end else begin
			csSync1 <= link.csN;
			csSync2 <= csSync1;
			csPrev <= csSync2;
		end
	end

	// Program/erase engine with pause and continue
	always_ff @(posedge clock) begin
		if (!resetn) begin
			state <= flash_srw_pkg::ENG_IDLE;
			runKind <= flash_srw_pkg::KIND_PROGRAM;
			remain <= '0;
			savedErase <= '0;
			savedProg <= '0;
			latTimer <= 16'h0000;
			erasePausedFlag <= 1'b0;
			programPausedFlag <= 1'b0;
			pausedOpFlag <= 1'b0;
			opFinished <= 1'b0;
			startRefused <= 1'b0;
		end else begin
			opFinished <= 1'b0;
			startRefused <= startOp && !startOk;
			case (state)
				flash_srw_pkg::ENG_IDLE: begin
					if (resumeOk) begin
						state <= flash_srw_pkg::ENG_RESUMING;
						latTimer <= 16'(CONTINUE_CYCLES);
						if (programPausedFlag) begin
							programPausedFlag <= 1'b0;
							pausedOpFlag <= erasePausedFlag;
							remain <= savedProg;
							runKind <= flash_srw_pkg::KIND_PROGRAM;
						end else begin
							erasePausedFlag <= 1'b0;
							pausedOpFlag <= 1'b0;
							remain <= savedErase;
							runKind <= flash_srw_pkg::KIND_ERASE;
						end
					end else if (startOk) begin
						state <= flash_srw_pkg::ENG_RUN;
						remain <= startCycles;
						runKind <= startKind;
					end
				end
				flash_srw_pkg::ENG_RUN: begin
					if (suspendOk) begin
						state <= flash_srw_pkg::ENG_PAUSING;
						latTimer <= 16'(PAUSE_CYCLES);
					end else if (remain <= CNT_W'(1)) begin
						state <= flash_srw_pkg::ENG_IDLE;
						opFinished <= 1'b1;
						remain <= '0;
					end else begin
						remain <= remain - CNT_W'(1);
					end
				end
				flash_srw_pkg::ENG_PAUSING: begin
					if (latTimer <= 16'h0001) begin
						state <= flash_srw_pkg::ENG_IDLE;
						pausedOpFlag <= 1'b1;
						if (runKind == flash_srw_pkg::KIND_ERASE) begin
							erasePausedFlag <= 1'b1;
							savedErase <= remain;
						end else begin
							programPausedFlag <= 1'b1;
							savedProg <= remain;
						end
					end else begin
						latTimer <= latTimer - 16'h0001;
					end
				end
				flash_srw_pkg::ENG_RESUMING: begin
					if (latTimer <= 16'h0001) begin
						state <= flash_srw_pkg::ENG_RUN;
					end else begin
						latTimer <= latTimer - 16'h0001;
					end
				end
				default: begin
					state <= flash_srw_pkg::ENG_IDLE;
				end
			endcase
		end
	end

	// Wrap setting and the quad-read address walker
	always_ff @(posedge clock) begin
		if (!resetn) begin
			wrapLengthBits <= flash_srw_pkg::WRAP_RESET;
			rdAddr <= 24'h00_0000;
		end else begin
			if (csRise && isSetWrap && frameWhole(clkCount, flash_srw_pkg::WRAP_FRAME_CLOCKS)) begin
				wrapLengthBits <= wrapByte[flash_srw_pkg::WRAP_FIELD_LSB +: 3];
			end
			if (rdLoad) begin
				rdAddr <= rdStart;
			end else if (rdStep) begin
				rdAddr <= wrapNext(rdAddr, wrapLengthBits);
			end
		end
	end
endmodule : flash_srw_device

// ==== core/flash_srw_host.sv ====
// Host controller end: issues pause, continue, wrap and status frames.
`timescale 1ns/10ps
module flash_srw_host #(
	parameter int HALF = flash_srw_pkg::SCLK_HALF
) (
	input wire logic clock,
	input wire logic resetn,
	flash_link_if.host link,
	input wire logic cmdReq,
	input wire flash_srw_pkg::host_cmd_e cmdOp,
	input wire logic [7:0] cmdWrap,
	output logic cmdReady,
	output logic [7:0] statusByte,
	output logic statusValid
);
	flash_srw_pkg::host_state_e hstate;
	logic [7:0] phase;
	logic [4:0] clkIdx;
	logic [4:0] lastIdx;
	logic [7:0] opByte;
	logic [7:0] wrapByte;
	logic isRead;
	logic isQuad;
	logic [7:0] shiftIn;
	logic sclkReg;
	logic csNReg;
	logic [3:0] ioOut;
	logic [3:0] ioOe;
	logic soSync1;
	logic soSync2;
	logic altPick;

	// Line values for one serial clock: opcode on line 0, then quad nibbles or a read turn
	function automatic logic [7:0] driveBits(input logic [4:0] idx, input logic [7:0] op, input logic [7:0] wrap,
		input logic quad);
		driveBits = 8'h00;
		if (idx < 5'(flash_srw_pkg::OPCODE_CLOCKS)) begin
			driveBits = {4'h1, 3'h0, op[3'h7 - idx[2:0]]};
		end else if (quad) begin
			if (idx == 5'(flash_srw_pkg::WRAP_NIB_FIRST)) begin
				driveBits = {4'hF, wrap[7:4]};
			end else if (idx > 5'(flash_srw_pkg::WRAP_NIB_FIRST)) begin
				driveBits = {4'hF, wrap[3:0]};
			end else begin
				driveBits = 8'hF0;
			end
		end
	endfunction : driveBits

	wire [7:0] lineSel;
	wire [7:0] reqOp;
	wire [7:0] pauseOp;
	wire [7:0] continueOp;
	wire sampleNow;
	wire frameDone;

	// Alternate between the two pause and the two continue opcodes, one frame to the next
	assign pauseOp = altPick ? flash_srw_pkg::OP_SUSPEND_B : flash_srw_pkg::OP_SUSPEND_A;
	assign continueOp = altPick ? flash_srw_pkg::OP_RESUME_B : flash_srw_pkg::OP_RESUME_A;
	assign frameDone = (clkIdx > lastIdx);
	assign lineSel = driveBits(clkIdx, opByte, wrapByte, isQuad);
	assign reqOp = (cmdOp == flash_srw_pkg::HCMD_SUSPEND) ? pauseOp :
		(cmdOp == flash_srw_pkg::HCMD_RESUME) ? continueOp :
		(cmdOp == flash_srw_pkg::HCMD_SET_WRAP) ? flash_srw_pkg::OP_SET_WRAP : flash_srw_pkg::OP_READ_STATUS;
	assign sampleNow = (phase == 8'(2 * HALF - 1));
	assign cmdReady = (hstate == flash_srw_pkg::H_IDLE);
	assign link.csN = csNReg;
	assign link.sclk = sclkReg;
	assign link.ioHost = ioOut;
	assign link.ioHostOe = ioOe;

	// Data line 1 from the device, synchronised
	always_ff @(posedge clock) begin
		if (!resetn) begin
			soSync1 <= 1'b0;
			soSync2 <= 1'b0;
		end else begin
			soSync1 <= link.io[1];
			soSync2 <= soSync1;
		end
	end

	// Frame sequencer; serial clock is a divider of the core clock, mode 0
	always_ff @(posedge clock) begin
		if (!resetn) begin
			hstate <= flash_srw_pkg::H_IDLE;
			phase <= 8'h00;
			clkIdx <= 5'h00;
			lastIdx <= 5'h00;
			opByte <= 8'h00;
			wrapByte <= 8'h00;
			isRead <= 1'b0;
			isQuad <= 1'b0;
			shiftIn <= 8'h00;
			sclkReg <= 1'b0;
			csNReg <= 1'b1;
			ioOut <= 4'h0;
			ioOe <= 4'h0;
			statusByte <= 8'h00;
			statusValid <= 1'b0;
			altPick <= 1'b0;
		end else begin
			statusValid <= 1'b0;
			case (hstate)
				flash_srw_pkg::H_IDLE: begin
					if (cmdReq) begin
						hstate <= flash_srw_pkg::H_SHIFT;
						altPick <= ~altPick;
						csNReg <= 1'b0;
						phase <= 8'h00;
						clkIdx <= 5'h00;
						opByte <= reqOp;
						wrapByte <= cmdWrap;
						isRead <= (cmdOp == flash_srw_pkg::HCMD_READ_STATUS);
						isQuad <= (cmdOp == flash_srw_pkg::HCMD_SET_WRAP);
						// Whole frames only, released on a byte boundary
						lastIdx <= (cmdOp == flash_srw_pkg::HCMD_SET_WRAP) ? 5'(flash_srw_pkg::WRAP_FRAME_CLOCKS - 1) :
							(cmdOp == flash_srw_pkg::HCMD_READ_STATUS) ? 5'(flash_srw_pkg::STATUS_FRAME_CLOCKS - 1) :
							5'(flash_srw_pkg::OPCODE_CLOCKS - 1);
					end
				end
				flash_srw_pkg::H_SHIFT: begin
					phase <= sampleNow ? 8'h00 : phase + 8'h01;
					// The last clock keeps its full high time; select rises with its falling edge
					if (phase == 8'h00 && frameDone) begin
						hstate <= flash_srw_pkg::H_GAP;
						phase <= 8'h00;
						sclkReg <= 1'b0;
						csNReg <= 1'b1;
						ioOe <= 4'h0;
					end else if (phase == 8'h00) begin
						sclkReg <= 1'b0;
						ioOe <= lineSel[7:4];
						ioOut <= lineSel[3:0];
					end else if (phase == 8'(HALF)) begin
						sclkReg <= 1'b1;
					end
					// Only the status byte is read back; no array data is relied on
					if (sampleNow) begin
						if (isRead && clkIdx >= 5'(flash_srw_pkg::OPCODE_CLOCKS)) begin
							shiftIn <= {shiftIn[6:0], soSync2};
						end
						clkIdx <= clkIdx + 5'h01;
					end
				end
				flash_srw_pkg::H_GAP: begin
					phase <= phase + 8'h01;
					if (phase == 8'(flash_srw_pkg::CS_GAP_CYCLES - 1)) begin
						hstate <= flash_srw_pkg::H_IDLE;
						phase <= 8'h00;
						statusValid <= isRead;
						statusByte <= shiftIn;
					end
				end
				default: begin
					hstate <= flash_srw_pkg::H_IDLE;
				end
			endcase
		end
	end
endmodule : flash_srw_host

// ==== sim/flash_srw_properties.sv ====
// Link checks between the host and device ends of the serial interface.
`timescale 1ns/10ps
module flash_srw_properties (
	input wire logic clock,
	input wire logic resetn,
	input wire logic csN,
	input wire logic sclk,
	input wire logic [3:0] ioHost,
	input wire logic [3:0] ioHostOe,
	input wire logic [3:0] ioDev,
	input wire logic [3:0] ioDevOe,
	input wire [3:0] io
);
	logic sclkQ;
	logic [5:0] clkCount;
	logic [7:0] opcode;
	wire sclkRise;
	// Serial clock rise as seen from the core clock
	assign sclkRise = sclk & ~sclkQ;
	// Count serial clocks in a frame and collect its opcode
	always_ff @(posedge clock) begin
		sclkQ <= resetn & sclk;
		if (!resetn || csN) begin
			clkCount <= 6'h0;
		end else if (sclkRise && clkCount != 6'h3F) begin
			clkCount <= clkCount + 6'h1;
		end
		if (!resetn) begin
			opcode <= 8'h0;
		end else if (sclkRise && clkCount < 6'h8) begin
			opcode <= {opcode[6:0], io[0]};
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	chk_sclk_idle_low: assert property (csN |-> !sclk)
		else $error("serial clock not low between frames");
	chk_lines_released: assert property (csN |-> ioHostOe == 4'h0 && ioDevOe == 4'h0)
		else $error("data line driven outside a frame");
	chk_select_gap: assert property ($rose(csN) |-> csN [*8])
		else $error("select gap shorter than eight clocks");
	chk_sclk_high_time: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
		else $error("serial clock high time wrong");
	chk_data_stable: assert property (sclk && $past(sclk) |-> $stable(ioHost) && $stable(ioHostOe))
		else $error("host data moved while serial clock high");
	chk_whole_bytes: assert property ($rose(csN) |-> clkCount >= 6'h8 && clkCount[2:0] == 3'h0)
		else $error("frame not ended on a byte boundary");
	chk_opcode_single: assert property (sclkRise && clkCount < 6'h8 |-> ioHostOe == 4'h1 && ioDevOe == 4'h0)
		else $error("opcode not on a single line");
	chk_quad_address: assert property (sclkRise && clkCount >= 6'h8
		&& opcode == flash_srw_pkg::OP_SET_WRAP |-> ioHostOe == 4'hF)
		else $error("wrap frame tail not on four lines");
	chk_status_out: assert property (sclkRise && clkCount >= 6'h8
		&& opcode == flash_srw_pkg::OP_READ_STATUS |-> ioDevOe[1] && !ioHostOe[1])
		else $error("status not driven by the device");
	chk_no_contention: assert property ((ioHostOe & ioDevOe) == 4'h0)
		else $error("both ends drive one line");
endmodule : flash_srw_properties

// ==== sim/tb_flash_suspend_resume_wrap.sv ====
// Self-checking bench for pause, continue and wrap commands across the serial link.
`timescale 1ns/10ps
module tb_flash_suspend_resume_wrap;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic cmdReq = 1'b0;
	flash_srw_pkg::host_cmd_e cmdOp = flash_srw_pkg::HCMD_READ_STATUS;
	logic [7:0] cmdWrap = 8'h00;
	logic cmdReady, statusValid;
	logic [7:0] statusByte, stat;
	logic startOp = 1'b0;
	flash_srw_pkg::op_kind_e startKind = flash_srw_pkg::KIND_PROGRAM;
	logic [15:0] startCycles = 16'h0000;
	logic writeLatch = 1'b0;
	logic rdLoad = 1'b0;
	logic rdStep = 1'b0;
	logic [23:0] rdStart = 24'h00_0000;
	logic busyFlag, pausedOpFlag, erasePausedFlag, programPausedFlag, startRefused, opFinished, r;
	logic [2:0] wrapLengthBits;
	logic [23:0] rdAddr;
	int numErrors = 0;
	int cmpCount = 0;
	int cycles = 0;
	flash_link_if link();
	always #12.5 clock = ~clock;
	flash_srw_host flash_srw_host_inst (.clock(clock), .resetn(resetn), .link(link), .cmdReq(cmdReq),
		.cmdOp(cmdOp), .cmdWrap(cmdWrap), .cmdReady(cmdReady), .statusByte(statusByte), .statusValid(statusValid));
	flash_srw_device #(.PAUSE_CYCLES(4), .CONTINUE_CYCLES(3)) flash_srw_device_inst (.clock(clock),
		.resetn(resetn), .link(link), .startOp(startOp), .startKind(startKind), .startCycles(startCycles),
		.writeLatch(writeLatch), .rdLoad(rdLoad), .rdStart(rdStart), .rdStep(rdStep), .busyFlag(busyFlag),
		.pausedOpFlag(pausedOpFlag), .erasePausedFlag(erasePausedFlag), .programPausedFlag(programPausedFlag),
		.wrapLengthBits(wrapLengthBits), .startRefused(startRefused), .opFinished(opFinished), .rdAddr(rdAddr));
	flash_srw_properties flash_srw_properties_inst (.clock(clock), .resetn(resetn), .csN(link.csN),
		.sclk(link.sclk), .ioHost(link.ioHost), .ioHostOe(link.ioHostOe), .ioDev(link.ioDev),
		.ioDevOe(link.ioDevOe), .io(link.io));
	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", cmpCount, numErrors);
		if (numErrors == 0 && cmpCount > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : report_and_stop
	task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
		cmpCount++;
		if (got !== exp) begin
			numErrors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	// Flags packed as busy, paused, erase paused, program paused
	task automatic flags(input logic [3:0] exp);
		check("flags", {20'h0, exp}, {20'h0, busyFlag, pausedOpFlag, erasePausedFlag, programPausedFlag});
	endtask : flags
	// One host frame; status is captured if the host reports one
	task automatic send(input flash_srw_pkg::host_cmd_e op, input logic [7:0] wrap);
		int n;
		stat = 8'hFF;
		@(posedge clock);
		cmdOp <= op;
		cmdWrap <= wrap;
		cmdReq <= 1'b1;
		@(posedge clock);
		cmdReq <= 1'b0;
		for (n = 0; n < 410; n++) begin
			@(posedge clock);
			#1;
			if (statusValid === 1'b1) stat = statusByte;
			if (cmdReady === 1'b1 && n < 400) n = 400;
		end
		check("frame done", 24'h1, {23'h0, cmdReady});
	endtask : send
	task automatic start(input flash_srw_pkg::op_kind_e kind, input logic wl, output logic refused);
		@(posedge clock);
		startOp <= 1'b1;
		startKind <= kind;
		startCycles <= 16'h0190;
		writeLatch <= wl;
		@(posedge clock);
		startOp <= 1'b0;
		#1;
		refused = startRefused;
		@(posedge clock);
		#1;
		refused = refused | startRefused;
	endtask : start
	task automatic waitDone(input string what);
		logic seen;
		seen = 1'b0;
		for (int n = 0; n < 800 && !seen; n++) begin
			@(posedge clock);
			#1;
			seen = (opFinished === 1'b1);
		end
		check(what, 24'h1, {23'h0, seen});
	endtask : waitDone
	task automatic t_program_pause();
		start(flash_srw_pkg::KIND_PROGRAM, 1'b0, r);
		check("program start refused", 24'h0, {23'h0, r});
		send(flash_srw_pkg::HCMD_SUSPEND, 8'h00);
		flags(4'h5);
		send(flash_srw_pkg::HCMD_READ_STATUS, 8'h00);
		check("status byte", 24'h14, {16'h0, stat});
		start(flash_srw_pkg::KIND_ERASE, 1'b0, r);
		check("erase start refused", 24'h1, {23'h0, r});
		send(flash_srw_pkg::HCMD_RESUME, 8'h00);
		flags(4'h8);
		waitDone("program finished");
		flags(4'h0);
	endtask : t_program_pause
	task automatic t_nested();
		start(flash_srw_pkg::KIND_ERASE, 1'b1, r);
		send(flash_srw_pkg::HCMD_SUSPEND, 8'h00);
		flags(4'h6);
		start(flash_srw_pkg::KIND_PROGRAM, 1'b1, r);
		check("program start refused", 24'h0, {23'h0, r});
		send(flash_srw_pkg::HCMD_SUSPEND, 8'h00);
		flags(4'h7);
		send(flash_srw_pkg::HCMD_READ_STATUS, 8'h00);
		check("status byte", 24'h1E, {16'h0, stat});
		send(flash_srw_pkg::HCMD_RESUME, 8'h00);
		flags(4'hE);
		waitDone("program finished");
		flags(4'h6);
		send(flash_srw_pkg::HCMD_RESUME, 8'h00);
		flags(4'h8);
		waitDone("erase finished");
	endtask : t_nested
	task automatic t_locked();
		send(flash_srw_pkg::HCMD_RESUME, 8'h00);
		flags(4'h0);
		start(flash_srw_pkg::KIND_LOCKED, 1'b0, r);
		send(flash_srw_pkg::HCMD_SUSPEND, 8'h00);
		flags(4'h8);
		send(flash_srw_pkg::HCMD_RESUME, 8'h00);
		flags(4'h8);
		waitDone("locked op finished");
	endtask : t_locked
	// Every wrap length, then wrap off with nonzero length bits
	task automatic t_wrap();
		logic [7:0] wb;
		logic [23:0] expAddr;
		for (int s = 0; s < 5; s++) begin
			wb = (s < 4) ? {1'b1, s[1:0], 5'h0A} : 8'hBF;
			expAddr = (s < 4) ? 24'h10_0040 - (24'h8 << s) : 24'h10_0040;
			send(flash_srw_pkg::HCMD_SET_WRAP, wb);
			check("wrap bits", {21'h0, wb[6:4]}, {21'h0, wrapLengthBits});
			@(posedge clock);
			rdLoad <= 1'b1;
			rdStart <= 24'h10_003F;
			@(posedge clock);
			rdLoad <= 1'b0;
			rdStep <= 1'b1;
			@(posedge clock);
			rdStep <= 1'b0;
			@(posedge clock);
			#1;
			check("address after section end", expAddr, rdAddr);
		end
	endtask : t_wrap
	// Cut a hung run short
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			numErrors++;
			$display("ERROR timeout expected completion seen hang");
			report_and_stop();
		end
	end
	// Main sequence
	initial begin
		repeat (2) @(posedge clock);
		resetn <= 1'b1;
		t_program_pause();
		t_nested();
		t_locked();
		t_wrap();
		report_and_stop();
	end
endmodule : tb_flash_suspend_resume_wrap
